// ---- tspc_consts.svh ----
/*
 * Register offsets, field positions, reset values and counts for the
 * single pulse / capture timer. Assumes a 3-bit word address and 16-bit data.
 */
`ifndef TSPC_CONSTS_SVH
`define TSPC_CONSTS_SVH

// register bus shape
`define TSPC_ADDR_W 3
`define TSPC_DATA_W 16
`define TSPC_CNT_W 10

// word offsets
`define TSPC_OFS_CTRL 3'h0
`define TSPC_OFS_COMPARE_VALUE_A 3'h1
`define TSPC_OFS_COMPARE_VALUE_P 3'h2
`define TSPC_OFS_COUNT 3'h3
`define TSPC_OFS_STATUS 3'h4

// control word occupies the low bits
`define TSPC_CTRL_W 11
`define TSPC_CTRL_RST 11'h000

// status bits, write one to clear
`define TSPC_STAT_A_BIT 0
`define TSPC_STAT_P_BIT 1

// counter limits
`define TSPC_CNT_MAX 10'h3ff
`define TSPC_CNT_ZERO 10'h000
`define TSPC_CNT_ONE 10'h001

// pin function codes
`define TSPC_PF_SINGLE 2'h3
`define TSPC_CAP_RISE 2'h0
`define TSPC_CAP_FALL 2'h1
`define TSPC_CAP_BOTH 2'h2
`define TSPC_CAP_OFF 2'h3

// prescaler terminal counts for /1, /4, /16, /64
`define TSPC_DIV_1 6'h00
`define TSPC_DIV_4 6'h03
`define TSPC_DIV_16 6'h0f
`define TSPC_DIV_64 6'h3f

`endif

// ---- tspc_pkg.sv ----
/*
 * Types of the single pulse / capture timer: mode codes, control word and
 * the state records of each module. Assumes tspc_consts.svh is on the path.
 */
`include "tspc_consts.svh"

package tspc_pkg;

   // mode select codes
   typedef enum logic [1:0] {
      TSPC_MODE_CMP = 2'h0,
      TSPC_MODE_CAP = 2'h1,
      TSPC_MODE_PULSE = 2'h2,
      TSPC_MODE_TMR = 2'h3
   } tspc_mode_t;

   // software control word, msb first
   typedef struct packed {
      logic counter_run_bit;
      tspc_mode_t mode_select;
      logic [1:0] pin_function;
      logic output_level_control;
      logic output_invert;
      logic clear_source_select;
      logic duty_period_swap;
      logic [1:0] clk_sel;
   } tspc_ctrl_t;

   typedef struct packed {
      tspc_ctrl_t ctrl;
      logic [`TSPC_CNT_W-1:0] compare_value_a;
      logic [`TSPC_CNT_W-1:0] compare_value_p;
      logic [`TSPC_CNT_W-1:0] cnt;
      logic flag_a;
      logic flag_p;
      logic irq_a;
      logic irq_p;
      logic timer_out;
      logic [`TSPC_DATA_W-1:0] rdata;
   } tspc_top_st_t;

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } tspc_sync_st_t;

   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } tspc_div_st_t;

endpackage : tspc_pkg

// ---- tspc_edge_sync.sv ----
/*
 * Two-flop synchroniser with edge detection for one pin.
 * Assumes the pin is asynchronous to clock; edges are one-cycle pulses.
 */
`timescale 1ns/10ps

module tspc_edge_sync import tspc_pkg::*; (
   input wire logic clock,
   input wire logic reset,
   input wire logic pin_in,
   output logic rise,
   output logic fall
);

   tspc_sync_st_t st_r;
   tspc_sync_st_t st_nxt;

   // meta feeds only the second flop
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = pin_in;
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // edges seen on settled samples only
   assign rise = st_r.sync & ~st_r.prev;
   assign fall = ~st_r.sync & st_r.prev;

endmodule : tspc_edge_sync

// ---- tspc_prescaler.sv ----
/*
 * Counter clock prescaler: one-cycle tick every 1, 4, 16 or 64 clocks.
 * Assumes a single clock; runs freely so the tick phase is not tied to run.
 */
`timescale 1ns/10ps
`include "tspc_consts.svh"

module tspc_prescaler import tspc_pkg::*; (
   input wire logic clock,
   input wire logic reset,
   input wire logic [1:0] clk_sel,
   output logic tick
);

   tspc_div_st_t st_r;
   tspc_div_st_t st_nxt;
   logic [5:0] limit;

   // terminal count per selection
   always_comb begin
      unique case (clk_sel)
         2'h0: limit = `TSPC_DIV_1;
         2'h1: limit = `TSPC_DIV_4;
         2'h2: limit = `TSPC_DIV_16;
         2'h3: limit = `TSPC_DIV_64;
      endcase
   end

   // >= keeps a lowered limit from waiting a full wrap
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt >= limit) begin
         st_nxt.cnt = 6'h00;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 6'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

endmodule : tspc_prescaler

// ---- tspc_top.sv ----
/*
 * Single pulse output and input capture modes of a 10-bit timer, with
 * control, compare and counter registers on a plain strobe port.
 * Assumes trigger and capture pins are asynchronous; bus is on clock.
 */

`timescale 1ns/10ps
`include "tspc_consts.svh"

module tspc_top import tspc_pkg::*; (
   input wire logic clock,
   input wire logic reset,
   input wire logic [`TSPC_ADDR_W-1:0] addr,
   input wire logic [`TSPC_DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [`TSPC_DATA_W-1:0] rd_data,
   input wire logic external_trigger_pin,
   input wire logic capture_input_pin,
   output logic timer_out,
   output logic irq_compare_a,
   output logic irq_compare_p
);

   tspc_top_st_t st_r;
   tspc_top_st_t st_nxt;
   logic tick;
   logic trig_rise;
   logic cap_rise;
   logic cap_fall;
   logic sp_match;
   logic cap_match_p;
   logic cap_hit;
   logic run_rise;

   // one-shot needs both the mode and the pin function code
   function automatic logic is_single(input tspc_ctrl_t c);
      return (c.mode_select == TSPC_MODE_PULSE)
         && (c.pin_function == `TSPC_PF_SINGLE);
   endfunction : is_single

   function automatic logic is_capture(input tspc_ctrl_t c);
      return c.mode_select == TSPC_MODE_CAP;
   endfunction : is_capture

   // edge select; code 11 never captures
   function automatic logic edge_hit(input logic [1:0] pf, input logic r,
                                     input logic f);
      unique case (pf)
         `TSPC_CAP_RISE: return r;
         `TSPC_CAP_FALL: return f;
         `TSPC_CAP_BOTH: return r | f;
         `TSPC_CAP_OFF: return 1'b0;
      endcase
   endfunction : edge_hit

   tspc_prescaler u_div (
      .clock(clock),
      .reset(reset),
      .clk_sel(st_r.ctrl.clk_sel),
      .tick(tick)
   );

   tspc_edge_sync u_trig (
      .clock(clock),
      .reset(reset),
      .pin_in(external_trigger_pin),
      .rise(trig_rise),
      .fall()
   );

   tspc_edge_sync u_cap (
      .clock(clock),
      .reset(reset),
      .pin_in(capture_input_pin),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   // events judged on registered state
   assign sp_match = is_single(st_r.ctrl) && st_r.ctrl.counter_run_bit && tick
      && (st_r.cnt == st_r.compare_value_a);
   assign cap_match_p = is_capture(st_r.ctrl) && st_r.ctrl.counter_run_bit
      && tick && (st_r.compare_value_p != `TSPC_CNT_ZERO)
      && (st_r.cnt == st_r.compare_value_p);
   assign cap_hit = is_capture(st_r.ctrl) && st_r.ctrl.counter_run_bit
      && edge_hit(st_r.ctrl.pin_function, cap_rise, cap_fall);

   // next state: bus writes first, hardware events after so they win
   always_comb begin
      st_nxt = st_r;
      st_nxt.irq_a = 1'b0;
      st_nxt.irq_p = 1'b0;
      st_nxt.rdata = 16'h0000;
      run_rise = 1'b0;
      if (wr_en) begin
         unique case (addr)
            `TSPC_OFS_CTRL: begin
               st_nxt.ctrl = tspc_ctrl_t'(wr_data[`TSPC_CTRL_W-1:0]);
            end
            `TSPC_OFS_COMPARE_VALUE_A: begin
               st_nxt.compare_value_a = wr_data[`TSPC_CNT_W-1:0];
            end
            `TSPC_OFS_COMPARE_VALUE_P: begin
               st_nxt.compare_value_p = wr_data[`TSPC_CNT_W-1:0];
            end
            `TSPC_OFS_STATUS: begin
               if (wr_data[`TSPC_STAT_A_BIT]) begin
                  st_nxt.flag_a = 1'b0;
               end
               if (wr_data[`TSPC_STAT_P_BIT]) begin
                  st_nxt.flag_p = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // match ends the pulse, trigger may restart it
      if (sp_match) begin
         st_nxt.ctrl.counter_run_bit = 1'b0;
         st_nxt.irq_a = 1'b1;
         st_nxt.flag_a = 1'b1;
      end
      if (is_single(st_r.ctrl) && trig_rise) begin
         st_nxt.ctrl.counter_run_bit = 1'b1;
      end
      run_rise = st_nxt.ctrl.counter_run_bit & ~st_r.ctrl.counter_run_bit;
      // counter: zeroed only by run rising in one-shot; compare_value_p unused there
      if (run_rise) begin
         st_nxt.cnt = `TSPC_CNT_ZERO;
      end else if (cap_match_p) begin
         st_nxt.cnt = `TSPC_CNT_ZERO;
         st_nxt.irq_p = 1'b1;
         st_nxt.flag_p = 1'b1;
      end else if (st_r.ctrl.counter_run_bit && tick && !sp_match
                   && (is_single(st_r.ctrl) || is_capture(st_r.ctrl))) begin
         st_nxt.cnt = st_r.cnt + `TSPC_CNT_ONE;
      end
      // capture overrides a same-cycle software write of compare_value_a
      if (cap_hit) begin
         st_nxt.compare_value_a = st_r.cnt;
         st_nxt.irq_a = 1'b1;
         st_nxt.flag_a = 1'b1;
      end
      // pulse level follows run; capture mode drives nothing
      if (is_single(st_nxt.ctrl)) begin
         st_nxt.timer_out = (st_nxt.ctrl.counter_run_bit
            ? st_nxt.ctrl.output_level_control
            : ~st_nxt.ctrl.output_level_control)
            ^ st_nxt.ctrl.output_invert;
      end else begin
         st_nxt.timer_out = 1'b0;
      end
      // read data valid the cycle after the strobe only
      if (rd_en) begin
         unique case (addr)
            `TSPC_OFS_CTRL: st_nxt.rdata = {5'h00, st_r.ctrl};
            `TSPC_OFS_COMPARE_VALUE_A: st_nxt.rdata = {6'h00, st_r.compare_value_a};
            `TSPC_OFS_COMPARE_VALUE_P: st_nxt.rdata = {6'h00, st_r.compare_value_p};
            `TSPC_OFS_COUNT: st_nxt.rdata = {6'h00, st_r.cnt};
            `TSPC_OFS_STATUS: st_nxt.rdata = {14'h0000, st_r.flag_p, st_r.flag_a};
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data = st_r.rdata;
   assign timer_out = st_r.timer_out;
   assign irq_compare_a = st_r.irq_a;
   assign irq_compare_p = st_r.irq_p;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // leading edge appears with the run bit
   AST_SP_LEAD: assert property (
      is_single(st_r.ctrl) && $rose(st_r.ctrl.counter_run_bit)
      |-> timer_out == (st_r.ctrl.output_level_control ^ st_r.ctrl.output_invert)
         && st_r.cnt == `TSPC_CNT_ZERO)
      else $error("pulse leading edge missing");

   // idle level whenever a one-shot is stopped
   AST_SP_TRAIL: assert property (
      is_single(st_r.ctrl) && !st_r.ctrl.counter_run_bit
      |-> timer_out == (~st_r.ctrl.output_level_control ^ st_r.ctrl.output_invert))
      else $error("pulse active while run is low");

   // match stops run, pulses irq a and freezes the count
   AST_SP_MATCH: assert property (
      sp_match && !trig_rise
      |=> !st_r.ctrl.counter_run_bit && irq_compare_a
         && st_r.cnt == $past(st_r.cnt))
      else $error("compare a match did not end the pulse");

   // trigger edge on a stopped one-shot starts the pulse from zero
   AST_SP_TRIG: assert property (
      is_single(st_r.ctrl) && trig_rise && !st_r.ctrl.counter_run_bit
      |=> st_r.ctrl.counter_run_bit ##0 st_r.cnt == `TSPC_CNT_ZERO)
      else $error("trigger did not start the pulse");

   // trigger has no say outside one-shot
   AST_TRIG_IGNORED: assert property (
      !is_single(st_r.ctrl) && trig_rise && !wr_en
      |=> $stable(st_r.ctrl.counter_run_bit))
      else $error("trigger acted outside one-shot");

   // any run rise zeroes the counter, in either mode
   AST_RUN_CLEARS: assert property (
      $rose(st_r.ctrl.counter_run_bit) |-> st_r.cnt == `TSPC_CNT_ZERO)
      else $error("counter not zeroed on run rise");

   // capture copies the count seen before the edge
   AST_CAP_LATCH: assert property (
      cap_hit |=> st_r.compare_value_a == $past(st_r.cnt) && irq_compare_a && st_r.flag_a)
      else $error("capture did not latch the counter");

   // compare p ends the capture count period
   AST_CAP_P: assert property (
      cap_match_p && !wr_en |=> st_r.cnt == `TSPC_CNT_ZERO && irq_compare_p)
      else $error("compare p match did not reset counter");

   // zero compare p lets the count roll over silently
   AST_CAP_WRAP: assert property (
      is_capture(st_r.ctrl) && st_r.ctrl.counter_run_bit && tick && !wr_en
      && st_r.compare_value_p == `TSPC_CNT_ZERO && st_r.cnt == `TSPC_CNT_MAX
      |=> st_r.cnt == `TSPC_CNT_ZERO && !irq_compare_p)
      else $error("counter did not wrap at maximum");

   // between limits the capture count steps by one
   AST_CAP_RUN: assert property (
      is_capture(st_r.ctrl) && st_r.ctrl.counter_run_bit && tick && !wr_en
      && st_r.cnt != st_r.compare_value_p && st_r.cnt != `TSPC_CNT_MAX
      |=> st_r.cnt == $past(st_r.cnt) + `TSPC_CNT_ONE)
      else $error("capture counter did not advance");

   // code 11 blocks capture; writes excluded since they may load compare_value_a
   AST_CAP_OFF: assert property (
      is_capture(st_r.ctrl) && st_r.ctrl.pin_function == `TSPC_CAP_OFF && !wr_en
      |=> $stable(st_r.compare_value_a) && !irq_compare_a)
      else $error("capture happened while disabled");

   // capture leaves the output pin low
   AST_CAP_NO_OUT: assert property (
      is_capture(st_r.ctrl) |-> !timer_out)
      else $error("output driven in capture mode");

   // one-shot counts each tick until compare A matches, wrapping at 10 bits
   AST_SP_ADVANCE: assert property (
      is_single(st_r.ctrl) && st_r.ctrl.counter_run_bit && tick && !sp_match
      |=> st_r.cnt == $past(st_r.cnt) + `TSPC_CNT_ONE)
      else $error("one-shot counter did not advance");

   // a stopped counter keeps its value; only a run rise may clear it
   AST_STOP_HOLDS: assert property (
      !st_r.ctrl.counter_run_bit && !wr_en && !trig_rise
      |=> $stable(st_r.cnt))
      else $error("stopped counter changed");

   // compare p never interrupts a one-shot
   AST_SP_NO_P: assert property (
      is_single(st_r.ctrl) |=> !irq_compare_p)
      else $error("compare p interrupt in one-shot");

   // in capture only an active edge raises irq a
   AST_CAP_IRQ_SRC: assert property (
      is_capture(st_r.ctrl) && !cap_hit |=> !irq_compare_a)
      else $error("compare a interrupt without capture edge");

   // capture events never stop the counter; only software does
   AST_CAP_KEEPS_RUN: assert property (
      is_capture(st_r.ctrl) && st_r.ctrl.counter_run_bit && !wr_en
      |=> st_r.ctrl.counter_run_bit)
      else $error("capture counter stopped by hardware");

endmodule : tspc_top

// ---- tspc_pin_src.sv ----
/*
 * Model of the pin-side sources: an external trigger and a capture signal.
 * Assumes the bench calls its tasks; pins change only just after a rising edge.
 */
`timescale 1ns/10ps

module tspc_pin_src (
   input wire logic clock,
   output logic trig_pin,
   output logic cap_pin
);
   // both pins idle low, as a pulled-down input would
   initial begin
      trig_pin = 1'b0;
      cap_pin = 1'b0;
   end

   // each level held 4 clocks so the two-flop sampler cannot miss it
   task automatic trigger_pulse();
      @(posedge clock) trig_pin <= 1'b1;
      repeat (4) @(posedge clock);
      trig_pin <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : trigger_pulse

   // one level change of the capture signal
   task automatic capture_level(input logic lvl);
      @(posedge clock) cap_pin <= lvl;
      repeat (4) @(posedge clock);
   endtask : capture_level
endmodule : tspc_pin_src

// ---- tspc_top_test.sv ----
/*
 * Self-checking bench for the one-shot and capture timer.
 * Assumes tspc_pkg, tspc_consts.svh and tspc_pin_src are compiled first.
 */
`timescale 1ns/10ps
`include "tspc_consts.svh"

module tspc_top_test import tspc_pkg::*; ();
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [15:0] wr_data = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [15:0] rd_data;
   logic trig_pin, cap_pin, timer_out, irq_compare_a, irq_compare_p;
   int errors = 0;
   int compares = 0;
   int na = 0;
   int np = 0;
   int cyc = 0;
   int exp_cap[4] = '{1, 1, 2, 0};
   logic [15:0] v, c1, c2;
   int a0, p0, w, t0;

   tspc_top i_dut (.clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .external_trigger_pin(trig_pin),
      .capture_input_pin(cap_pin), .timer_out(timer_out), .irq_compare_a(irq_compare_a),
      .irq_compare_p(irq_compare_p));
   tspc_pin_src i_src (.clock(clock), .trig_pin(trig_pin), .cap_pin(cap_pin));

   // 50 ns clock
   always #25 clock = ~clock;

   // interrupt pulse and cycle counters
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (irq_compare_a === 1'b1) na <= na + 1;
      if (irq_compare_p === 1'b1) np <= np + 1;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock) begin
         addr <= a;
         wr_data <= d;
         wr_en <= 1'b1;
      end
      @(posedge clock) wr_en <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clock) begin
         addr <= a;
         rd_en <= 1'b1;
      end
      @(posedge clock) rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   function automatic logic [15:0] ctl(logic run, tspc_mode_t m, logic [1:0] pf,
                                       logic [3:0] misc);
      tspc_ctrl_t c;
      c = {run, m, pf, misc, 2'h0};
      return {5'h00, c};
   endfunction : ctl

   // bounded wait for a new compare A (sel 0) or compare P (sel 1) pulse
   task automatic wait_irq(input int n, input bit sel);
      int k;
      k = 0;
      while (((sel ? np : na) == n) && k < 2000) begin
         @(posedge clock);
         #1 k++;
      end
      check("irq wait", 16'(k < 2000), 16'h0001);
   endtask : wait_irq

   task automatic final_report();
      $display("checks %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   // watchdog, over twenty times the expected run length
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      final_report();
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      for (int a = 0; a < 6; a++) begin
         rd(3'(a), v);
         check("reset value", v, 16'h0000);
      end
      wr(`TSPC_OFS_COMPARE_VALUE_A, 16'hffff);
      rd(`TSPC_OFS_COMPARE_VALUE_A, v);
      check("compare_value_a width", v, 16'h03ff);
      $display("test reset done");

      // one-shot with compare P, clear select and swap set to show they are ignored
      wr(`TSPC_OFS_COMPARE_VALUE_P, 16'h0003);
      wr(`TSPC_OFS_COMPARE_VALUE_A, 16'h0008);
      a0 = na;
      p0 = np;
      wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_PULSE, 2'h3, 4'hb));
      #1 w = 0;
      while (timer_out === 1'b1 && w < 1100) begin
         @(posedge clock);
         #1 w++;
      end
      check("pulse width", 16'(w == 9 || w == 10), 16'h0001);
      repeat (2) @(posedge clock);
      check("irq a count", 16'(na - a0), 16'h0001);
      check("irq p count", 16'(np - p0), 16'h0000);
      rd(`TSPC_OFS_COUNT, v);
      check("held count", v, 16'h0008);
      rd(`TSPC_OFS_CTRL, v);
      check("run cleared", 16'(v[10]), 16'h0000);
      rd(`TSPC_OFS_STATUS, v);
      check("flag a", 16'(v[0]), 16'h0001);
      wr(`TSPC_OFS_STATUS, 16'h0003);
      rd(`TSPC_OFS_STATUS, v);
      check("status clear", v, 16'h0000);
      $display("test one-shot done");

      // software stop mid-pulse, then restart zeroes the counter
      wr(`TSPC_OFS_COMPARE_VALUE_A, 16'h00c8);
      wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_PULSE, 2'h3, 4'h8));
      repeat (10) @(posedge clock);
      wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_PULSE, 2'h3, 4'h8));
      @(posedge clock);
      #1 check("stopped out", 16'(timer_out), 16'h0000);
      rd(`TSPC_OFS_COUNT, c1);
      repeat (5) @(posedge clock);
      rd(`TSPC_OFS_COUNT, c2);
      check("count held", 16'(c1 == c2 && c1 != 0), 16'h0001);
      wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_PULSE, 2'h3, 4'h8));
      rd(`TSPC_OFS_COUNT, v);
      check("restart zero", 16'(v < 4), 16'h0001);
      wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_PULSE, 2'h3, 4'h8));
      $display("test stop done");

      // counter clock divided by four: four ticks of compare A span 13 to 16 clocks
      wr(`TSPC_OFS_COMPARE_VALUE_A, 16'h0003);
      wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_PULSE, 2'h3, 4'h8) | 16'h0001);
      #1 w = 0;
      while (timer_out === 1'b1 && w < 1100) begin
         @(posedge clock);
         #1 w++;
      end
      check("divided width", 16'(w >= 13 && w <= 16), 16'h0001);
      wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_PULSE, 2'h3, 4'h8));
      $display("test divider done");

      // trigger pin starts a pulse only in one-shot operation
      wr(`TSPC_OFS_COMPARE_VALUE_A, 16'h0028);
      a0 = na;
      i_src.trigger_pulse();
      rd(`TSPC_OFS_CTRL, v);
      check("trigger run", 16'(v[10]), 16'h0001);
      check("trigger out", 16'(timer_out), 16'h0001);
      wait_irq(a0, 0);
      wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_CAP, 2'h0, 4'h0));
      i_src.trigger_pulse();
      rd(`TSPC_OFS_CTRL, v);
      check("trigger ignored", 16'(v[10]), 16'h0000);
      $display("test trigger done");

      // each capture edge selection, output bits set to show there is no output
      wr(`TSPC_OFS_COMPARE_VALUE_P, 16'h0000);
      for (int pf = 0; pf < 4; pf++) begin
         wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_CAP, 2'(pf), 4'hf));
         wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_CAP, 2'(pf), 4'hf));
         a0 = na;
         i_src.capture_level(1'b1);
         i_src.capture_level(1'b0);
         repeat (4) @(posedge clock);
         check("capture pulses", 16'(na - a0), 16'(exp_cap[pf]));
         check("capture out", 16'(timer_out), 16'h0000);
      end
      $display("test edges done");

      // captured value tracks the running counter
      wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_CAP, 2'h0, 4'h0));
      wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_CAP, 2'h0, 4'h0));
      t0 = cyc;
      a0 = na;
      repeat (30) @(posedge clock);
      i_src.capture_level(1'b1);
      wait_irq(a0, 0);
      w = cyc - t0;
      rd(`TSPC_OFS_COMPARE_VALUE_A, v);
      check("capture value", 16'(v <= w && v + 6 >= w), 16'h0001);
      rd(`TSPC_OFS_COUNT, c1);
      check("free run", 16'(c1 > v), 16'h0001);
      i_src.capture_level(1'b0);
      $display("test capture done");

      // compare P limits the count; zero lets it wrap at the top
      wr(`TSPC_OFS_COMPARE_VALUE_P, 16'h0014);
      p0 = np;
      wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_CAP, 2'h3, 4'h0));
      wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_CAP, 2'h3, 4'h0));
      wait_irq(p0, 1);
      rd(`TSPC_OFS_COUNT, v);
      check("p reset", 16'(v < 8), 16'h0001);
      rd(`TSPC_OFS_STATUS, v);
      check("flag p", 16'(v[1]), 16'h0001);
      wr(`TSPC_OFS_COMPARE_VALUE_P, 16'h0000);
      wr(`TSPC_OFS_CTRL, ctl(0, TSPC_MODE_CAP, 2'h3, 4'h0));
      wr(`TSPC_OFS_CTRL, ctl(1, TSPC_MODE_CAP, 2'h3, 4'h0));
      p0 = np;
      repeat (700) @(posedge clock);
      rd(`TSPC_OFS_COUNT, v);
      check("long count", 16'(v >= 690 && v <= 16'h03ff), 16'h0001);
      repeat (400) @(posedge clock);
      rd(`TSPC_OFS_COUNT, v);
      check("wrapped", 16'(v < 16'h0080), 16'h0001);
      check("no p irq", 16'(np - p0), 16'h0000);
      $display("test compare p done");
      final_report();
   end
endmodule : tspc_top_test
